/* rtl/rac_agc.sv */
// Receiver gain loop, signal-strength capture and offset-correction clock.
// Assumes clk is the crystal at 40 MHz; config and level inputs are synchronous.
`timescale 1ns/1ps
module rac_agc
	import rac_pkg::*;
#(
	parameter int unsigned CLK_HZ = RAC_CLK_HZ
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire rac_cfg_t      cfg,
	input  wire logic          cfg_write,
	input  wire logic [6:0]    level_in,
	input  wire logic          level_valid,
	output logic               front_amp_power_mode,
	output logic [1:0]         front_amp_gain_code,
	output logic [1:0]         filt_gain_code,
	output logic               mixer_linearity,
	output logic               offset_correction_clock,
	output logic               agc_settling,
	output rac_readback_t      readback
);

	localparam int unsigned SEQ_CYCLES = CLK_HZ / RAC_SEQ_HZ;

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (SEQ_CYCLES < 2 || SEQ_CYCLES > 512) begin : g_bad_clk
		$error("CLK_HZ gives a sequencer divide outside 2..512");
	end

	rac_cfg_t   cfg_q;
	rac_state_t state_q;
	logic [2:0] step_q;
	logic [6:0] level_q;
	logic       level_new_q;
	logic [5:0] settle_q;
	logic       seq_tick;
	logic       ofs_tick;
	logic [1:0] amp_tbl;
	logic [1:0] filt_tbl;
	logic [4:0] ofs_limit;

	// ----------------------------------------------------------------
	// Configuration store
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= RAC_CFG_RST;
		end else if (cfg_write) begin
			cfg_q <= cfg;
		end
	end

	// ----------------------------------------------------------------
	// Level capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level_q     <= 7'h00;
			level_new_q <= 1'b0;
		end else begin
			level_new_q <= level_valid;
			if (level_valid) begin
				level_q <= (level_in > RAC_LEVEL_MAX) ? RAC_LEVEL_MAX : level_in;
			end
		end
	end

	// ----------------------------------------------------------------
	// Dividers
	// ----------------------------------------------------------------
	rac_divider #(
		.W(9)
	) u_seq_div (
		.clk  (clk),
		.rst  (rst),
		.en   (state_q == RAC_ST_SETTLE),
		.limit(9'(SEQ_CYCLES - 1)),
		.tick (seq_tick)
	);

	assign ofs_limit = 5'((RAC_OFS_BASE << cfg_q.offset_correction_divider) - 5'h01);

	rac_divider #(
		.W(5)
	) u_ofs_div (
		.clk  (clk),
		.rst  (rst),
		.en   (1'b1),
		.limit(ofs_limit),
		.tick (ofs_tick)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			offset_correction_clock <= 1'b0;
		end else if (ofs_tick) begin
			offset_correction_clock <= ~offset_correction_clock;
		end
	end

	// ----------------------------------------------------------------
	// Gain loop state machine
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q  <= RAC_ST_COMPARE;
			step_q   <= 3'h0;
			settle_q <= 6'h00;
		end else if (!cfg_q.agc_on) begin
			state_q  <= RAC_ST_HOLD;
			settle_q <= 6'h00;
		end else begin
			case (state_q)
				RAC_ST_HOLD: begin
					state_q <= RAC_ST_COMPARE;
				end
				RAC_ST_COMPARE: begin
					if (level_new_q && level_q > cfg_q.gain_upper_limit
						&& step_q < RAC_STEP_MAX) begin
						step_q   <= step_q + 3'h1;
						settle_q <= 6'h00;
						state_q  <= RAC_ST_SETTLE;
					end else if (level_new_q && level_q < cfg_q.gain_lower_limit
						&& step_q != 3'h0) begin
						step_q   <= step_q - 3'h1;
						settle_q <= 6'h00;
						state_q  <= RAC_ST_SETTLE;
					end
				end
				RAC_ST_SETTLE: begin
					if (seq_tick) begin
						if (settle_q + 6'h01 >= cfg_q.gain_settle_divider) begin
							state_q <= RAC_ST_COMPARE;
						end
						settle_q <= settle_q + 6'h01;
					end
				end
				default: begin
					state_q <= RAC_ST_COMPARE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Gain table and outputs
	// ----------------------------------------------------------------
	always_comb begin
		case (step_q)
			3'h0:    {amp_tbl, filt_tbl} = {RAC_GAIN_H, RAC_GAIN_H};
			3'h1:    {amp_tbl, filt_tbl} = {RAC_GAIN_M, RAC_GAIN_H};
			3'h2:    {amp_tbl, filt_tbl} = {RAC_GAIN_M, RAC_GAIN_M};
			3'h3:    {amp_tbl, filt_tbl} = {RAC_GAIN_M, RAC_GAIN_L};
			default: {amp_tbl, filt_tbl} = {RAC_GAIN_L, RAC_GAIN_L};
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			front_amp_power_mode <= 1'b0;
			front_amp_gain_code  <= RAC_GAIN_H;
			filt_gain_code       <= RAC_GAIN_H;
			mixer_linearity      <= 1'b0;
			agc_settling         <= 1'b0;
		end else if (cfg_q.agc_on) begin
			front_amp_power_mode <= 1'b0;
			front_amp_gain_code  <= amp_tbl;
			filt_gain_code       <= filt_tbl;
			mixer_linearity      <= cfg_q.mixer_linearity;
			agc_settling         <= (state_q == RAC_ST_SETTLE);
		end else begin
			front_amp_power_mode <= cfg_q.front_amp_power_mode;
			front_amp_gain_code  <= cfg_q.front_amp_gain_code;
			filt_gain_code       <= cfg_q.filt_gain_code;
			mixer_linearity      <= cfg_q.mixer_linearity;
			agc_settling         <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Readback
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			readback <= '0;
		end else begin
			readback.level_code     <= level_q;
			readback.amp_gain_bits  <= front_amp_gain_code;
			readback.filt_gain_bits <= filt_gain_code;
			readback.spare          <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_lower_gain;
		@(posedge clk) disable iff (rst)
		(cfg_q.agc_on && state_q == RAC_ST_COMPARE && level_new_q
			&& level_q > cfg_q.gain_upper_limit && step_q < RAC_STEP_MAX)
		|=> step_q == $past(step_q) + 3'h1 && state_q == RAC_ST_SETTLE;
	endproperty
	a_lower_gain: assert property (p_lower_gain) else $error("gain not lowered");

	property p_raise_gain;
		@(posedge clk) disable iff (rst)
		(cfg_q.agc_on && state_q == RAC_ST_COMPARE && level_new_q
			&& level_q < cfg_q.gain_lower_limit && step_q != 3'h0)
		|=> step_q == $past(step_q) - 3'h1;
	endproperty
	a_raise_gain: assert property (p_raise_gain) else $error("gain not raised");

	property p_reset_limits;
		@(posedge clk)
		$fell(rst) |-> cfg_q.gain_lower_limit == 7'h1E && cfg_q.gain_upper_limit == 7'h46
			&& cfg_q.agc_on;
	endproperty
	a_reset_limits: assert property (p_reset_limits) else $error("bad reset limits");

	property p_settle_hold;
		@(posedge clk) disable iff (rst)
		(state_q == RAC_ST_SETTLE && !seq_tick && cfg_q.agc_on) |=> $stable(step_q);
	endproperty
	a_settle_hold: assert property (p_settle_hold) else $error("gain moved while settling");

	property p_settle_min;
		@(posedge clk) disable iff (rst)
		($rose(state_q == RAC_ST_SETTLE) && cfg_q.gain_settle_divider >= 6'h08 && !cfg_write)
		|-> (state_q == RAC_ST_SETTLE) [*8];
	endproperty
	a_settle_min: assert property (p_settle_min) else $error("settle too short");

	property p_step_range;
		@(posedge clk) disable iff (rst)
		step_q <= RAC_STEP_MAX;
	endproperty
	a_step_range: assert property (p_step_range) else $error("step out of range");

	property p_manual;
		@(posedge clk) disable iff (rst)
		!cfg_q.agc_on |=> front_amp_gain_code == $past(cfg_q.front_amp_gain_code)
			&& filt_gain_code == $past(cfg_q.filt_gain_code)
			&& front_amp_power_mode == $past(cfg_q.front_amp_power_mode);
	endproperty
	a_manual: assert property (p_manual) else $error("manual gains not applied");

	property p_ofs_toggle;
		@(posedge clk) disable iff (rst)
		ofs_tick |=> offset_correction_clock != $past(offset_correction_clock);
	endproperty
	a_ofs_toggle: assert property (p_ofs_toggle) else $error("offset clock stuck");

	property p_readback;
		@(posedge clk) disable iff (rst)
		level_valid |=> ##1 !readback.spare && readback.level_code
			== (($past(level_in, 2) > RAC_LEVEL_MAX) ? RAC_LEVEL_MAX : $past(level_in, 2));
	endproperty
	a_readback: assert property (p_readback) else $error("readback level wrong");

	property p_frozen;
		@(posedge clk) disable iff (rst)
		(!cfg_q.agc_on && !$past(cfg_q.agc_on)) |-> $stable(step_q);
	endproperty
	a_frozen: assert property (p_frozen) else $error("loop moved while off");

	c_settle: cover property (@(posedge clk) disable iff (rst)
		state_q == RAC_ST_SETTLE ##[1:1000] state_q == RAC_ST_COMPARE);
	c_min_gain: cover property (@(posedge clk) disable iff (rst) step_q == RAC_STEP_MAX);
	c_manual: cover property (@(posedge clk) disable iff (rst) state_q == RAC_ST_HOLD);

endmodule

/* inc/rac_pkg.sv */
// Receiver gain loop and signal-strength readback: shared constants and types.
// Assumes one 40 MHz clock, which is also the crystal reference for the dividers.
package rac_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned RAC_CLK_HZ     = 40_000_000;
	localparam int unsigned RAC_SEQ_HZ     = 100_000;
	localparam int unsigned RAC_SEQ_CYCLES = RAC_CLK_HZ / RAC_SEQ_HZ;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [6:0] RAC_LOWER_RST   = 7'h1E;
	localparam logic [6:0] RAC_UPPER_RST   = 7'h46;
	localparam logic [5:0] RAC_SETTLE_RST  = 6'h0D;
	localparam logic [6:0] RAC_LEVEL_MAX   = 7'h4F;
	localparam logic [2:0] RAC_STEP_MAX    = 3'h4;
	localparam logic [4:0] RAC_OFS_BASE    = 5'h02;

	// ----------------------------------------------------------------
	// Gain bit encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] RAC_GAIN_H = 2'h2;
	localparam logic [1:0] RAC_GAIN_M = 2'h1;
	localparam logic [1:0] RAC_GAIN_L = 2'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RAC_ST_HOLD    = 2'h0,
		RAC_ST_COMPARE = 2'h1,
		RAC_ST_SETTLE  = 2'h3
	} rac_state_t;

	typedef struct packed {
		logic       agc_on;
		logic [6:0] gain_upper_limit;
		logic [6:0] gain_lower_limit;
		logic [5:0] gain_settle_divider;
		logic [1:0] offset_correction_divider;
		logic       front_amp_power_mode;
		logic [1:0] front_amp_gain_code;
		logic       mixer_linearity;
		logic [1:0] filt_gain_code;
	} rac_cfg_t;

	localparam rac_cfg_t RAC_CFG_RST = '{
		agc_on:                    1'b1,
		gain_upper_limit:          RAC_UPPER_RST,
		gain_lower_limit:          RAC_LOWER_RST,
		gain_settle_divider:       RAC_SETTLE_RST,
		offset_correction_divider: 2'h0,
		front_amp_power_mode:      1'b0,
		front_amp_gain_code:       2'h0,
		mixer_linearity:           1'b0,
		filt_gain_code:            2'h0
	};

	typedef struct packed {
		logic [1:0] amp_gain_bits;
		logic [1:0] filt_gain_bits;
		logic [6:0] level_code;
		logic       spare;
	} rac_readback_t;

endpackage

/* rtl/rac_divider.sv */
// Programmable tick divider: one-cycle pulse every limit+1 enabled cycles.
// Assumes a single clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
module rac_divider #(
	parameter int unsigned W = 9
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         en,
	input  wire logic [W-1:0] limit,
	output logic              tick
);

	logic [W-1:0] count_q;

	// ----------------------------------------------------------------
	// Counter and tick
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= '0;
			tick    <= 1'b0;
		end else if (!en) begin
			count_q <= '0;
			tick    <= 1'b0;
		end else if (count_q >= limit) begin
			count_q <= '0;
			tick    <= 1'b1;
		end else begin
			count_q <= count_q + 1'b1;
			tick    <= 1'b0;
		end
	end

endmodule

/* tb/rac_host_model.sv */
// Host-side model: writes the receiver config word and presents level samples.
// Assumes tasks are called from the bench; all changes land just after a rising clk edge.
`timescale 1ns/1ps
module rac_host_model
	import rac_pkg::*;
(
	input  wire logic clk,
	output rac_cfg_t   cfg,
	output logic       cfg_write,
	output logic [6:0] level_in,
	output logic       level_valid
);
	initial begin
		cfg         = RAC_CFG_RST;
		cfg_write   = 1'b0;
		level_in    = 7'h00;
		level_valid = 1'b0;
	end

	// ----------------------------------------------------------------
	// Config writes
	// ----------------------------------------------------------------
	// Limits kept more than 30 apart, settle divider left at 13
	task automatic write_cfg(input rac_cfg_t c);
		@(posedge clk);
		cfg       <= c;
		cfg_write <= 1'b1;
		@(posedge clk);
		cfg       <= ~c;
		cfg_write <= 1'b0;
	endtask

	// Fixed medium gain with enhanced linearity, loop off
	task automatic write_manual(input rac_cfg_t base);
		rac_cfg_t m;
		m                      = base;
		m.agc_on               = 1'b0;
		m.front_amp_power_mode = 1'b1;
		m.front_amp_gain_code  = 2'h1;
		m.mixer_linearity      = 1'b1;
		m.filt_gain_code       = 2'h1;
		write_cfg(m);
	endtask

	// ----------------------------------------------------------------
	// Level samples
	// ----------------------------------------------------------------
	task automatic send_level(input logic [6:0] l);
		@(posedge clk);
		level_in    <= l;
		level_valid <= 1'b1;
		@(posedge clk);
		level_in    <= ~l;
		level_valid <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Power conversion
	// ----------------------------------------------------------------
	// Correction by amp and filter gain bits
	function automatic int gain_corr(input logic [3:0] g);
		case (g)
			4'hA:    gain_corr = 0;
			4'h6:    gain_corr = 24;
			4'h5:    gain_corr = 38;
			4'h4:    gain_corr = 58;
			4'h0:    gain_corr = 86;
			default: gain_corr = -1000;
		endcase
	endfunction

	// Twice the input power in dBm: -260 plus code plus correction
	function automatic int dbm_x2(input rac_readback_t r);
		dbm_x2 = -260 + int'(r.level_code) + gain_corr({r.amp_gain_bits, r.filt_gain_bits});
	endfunction
endmodule

/* tb/rac_agc_tb.sv */
// Bench for the receiver gain loop: gain steps, limits, manual mode, offset clock.
// Assumes rac_host_model drives config and levels; sequencer rate scaled through CLK_HZ.
`timescale 1ns/1ps
module rac_agc_tb
	import rac_pkg::*;
();
	localparam int unsigned SIM_HZ = 400_000;
	localparam int          SETTLE = 13 * (SIM_HZ / RAC_SEQ_HZ);
	localparam logic [3:0]  STEP [5] = '{4'hA, 4'h6, 4'h5, 4'h4, 4'h0};
	localparam int          CORR [5] = '{0, 24, 38, 58, 86};

	logic          clk;
	logic          rst;
	rac_cfg_t      cfg;
	rac_cfg_t      c;
	logic          cfg_write;
	logic [6:0]    level_in;
	logic          level_valid;
	logic          front_amp_power_mode;
	logic [1:0]    front_amp_gain_code;
	logic [1:0]    filt_gain_code;
	logic          mixer_linearity;
	logic          offset_correction_clock;
	logic          agc_settling;
	rac_readback_t readback;
	int            errors;
	int            n_compared;

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	rac_host_model i_rac_host_model (
		.clk         (clk),
		.cfg         (cfg),
		.cfg_write   (cfg_write),
		.level_in    (level_in),
		.level_valid (level_valid)
	);

	rac_agc #(.CLK_HZ(SIM_HZ)) i_rac_agc (
		.clk                     (clk),
		.rst                     (rst),
		.cfg                     (cfg),
		.cfg_write               (cfg_write),
		.level_in                (level_in),
		.level_valid             (level_valid),
		.front_amp_power_mode    (front_amp_power_mode),
		.front_amp_gain_code     (front_amp_gain_code),
		.filt_gain_code          (filt_gain_code),
		.mixer_linearity         (mixer_linearity),
		.offset_correction_clock (offset_correction_clock),
		.agc_settling            (agc_settling),
		.readback                (readback)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [11:0] gains();
		gains = 12'({front_amp_gain_code, filt_gain_code});
	endfunction

	function automatic logic [11:0] outs();
		outs = 12'({front_amp_power_mode, front_amp_gain_code, mixer_linearity, filt_gain_code});
	endfunction

	task automatic lg(input string nm, input logic [6:0] l, input int k);
		i_rac_host_model.send_level(l);
		repeat (2) @(posedge clk);
		#1;
		chk(nm, gains(), 12'(STEP[k]));
	endtask

	task automatic settle();
		int n;
		n = 0;
		while (agc_settling === 1'b1 && n < 400) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("settle_len", 12'(n >= SETTLE - 8 && n <= SETTLE + 4), 12'h001);
	endtask

	task automatic ofs_period(input logic [1:0] d);
		int   r;
		int   t1;
		int   t2;
		logic prev;
		#1;
		r    = 0;
		t1   = 0;
		t2   = 0;
		prev = offset_correction_clock;
		for (int i = 0; i < 200 && r < 3; i++) begin
			@(posedge clk);
			#1;
			if (offset_correction_clock === 1'b1 && prev === 1'b0) begin
				r++;
				if (r == 2) t1 = i;
				if (r == 3) t2 = i;
			end
			prev = offset_correction_clock;
		end
		chk("ofs_period", 12'(t2 - t1), 12'(4 << d));
	endtask

	task automatic wrap_up();
		if (errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		errors     = 0;
		n_compared = 0;
		rst        = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("rst_gain", gains(), 12'(STEP[0]));
		chk("rst_misc", 12'({front_amp_power_mode, agc_settling}), 12'h000);
		lg("at_upper", 7'h46, 0);
		lg("at_lower", 7'h1E, 0);
		for (int k = 1; k < 5; k++) begin
			lg("down", 7'h47, k);
			chk("settling", 12'(agc_settling), 12'h001);
			lg("in_settle", 7'h7F, k);
			chk("readback", 12'(readback), {STEP[k], 7'h4F, 1'b0});
			chk("dbm_x2", 12'(i_rac_host_model.dbm_x2(readback)), 12'(-181 + CORR[k]));
			settle();
		end
		lg("floor", 7'h4F, 4);
		for (int k = 3; k >= 0; k--) begin
			lg("up", 7'h1D, k);
			settle();
		end
		lg("ceiling", 7'h00, 0);
		chk("no_settle", 12'(agc_settling), 12'h000);
		c                  = RAC_CFG_RST;
		c.gain_upper_limit = 7'h32;
		c.gain_lower_limit = 7'h0A;
		i_rac_host_model.write_cfg(c);
		lg("new_upper_eq", 7'h32, 0);
		lg("new_upper", 7'h33, 1);
		settle();
		lg("new_lower_eq", 7'h0A, 1);
		lg("new_lower", 7'h09, 0);
		settle();
		i_rac_host_model.write_manual(c);
		@(posedge clk);
		#1;
		chk("manual", outs(), 12'h02D);
		lg("man_high", 7'h7F, 2);
		lg("man_low", 7'h00, 2);
		// Sweep ends at ratio 32, 1.25 MHz from the 40 MHz crystal
		for (int d = 0; d < 4; d++) begin
			c.offset_correction_divider = 2'(d);
			i_rac_host_model.write_cfg(c);
			ofs_period(2'(d));
		end
		lg("resume", 7'h47, 1);
		chk("mode_on", 12'(front_amp_power_mode), 12'h000);
		settle();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("rst2_gain", gains(), 12'(STEP[0]));
		lg("rst2_upper_eq", 7'h46, 0);
		lg("rst2_upper", 7'h47, 1);
		settle();
		wrap_up();
	end

	initial begin
		#200_000;
		errors++;
		wrap_up();
	end
endmodule
